// *** rtl/pbdp_pkg.sv ***
// Shared constants and types for the bitstream data pacing link
package pbdp_pkg;
	localparam int DATA_W = 32;
	localparam int KEY_W = 256;
	localparam int RATIO_W = 4;
	localparam int FIFO_DEPTH = 8;
	// Width selector encodings
	typedef enum logic [1:0] {
		PBDP_W8 = 2'h0,
		PBDP_W16 = 2'h1,
		PBDP_W32 = 2'h2
	} pbdp_width_t;
	// Key store selection
	typedef enum logic {
		PBDP_KEY_VOLATILE = 1'h0,
		PBDP_KEY_OTP = 1'h1
	} pbdp_keystore_t;
	// Data-hold ratio table entries
	localparam logic [RATIO_W-1:0] RATIO_PLAIN = 4'h1;
	localparam logic [RATIO_W-1:0] RATIO_CMP_X8 = 4'h2;
	localparam logic [RATIO_W-1:0] RATIO_CMP_X16 = 4'h4;
	localparam logic [RATIO_W-1:0] RATIO_CMP_X32 = 4'h8;
	localparam logic [RATIO_W-1:0] RATIO_AES_X8 = 4'h1;
	localparam logic [RATIO_W-1:0] RATIO_AES_X16 = 4'h2;
	localparam logic [RATIO_W-1:0] RATIO_AES_X32 = 4'h4;
	localparam logic [RATIO_W-1:0] RATIO_ZERO = 4'h0;
	localparam logic [RATIO_W-1:0] RATIO_ONE = 4'h1;

	// Ratio lookup; returns zero for an unsupported combination
	function automatic logic [RATIO_W-1:0] pbdp_ratio(input pbdp_width_t width, input logic aes,
		input logic cmp, input logic enh);
		pbdp_width_t w;
		logic [RATIO_W-1:0] r;
		w = enh ? PBDP_W16 : width;
		r = RATIO_ZERO;
		if ((aes && cmp) || (aes && enh)) begin
			r = RATIO_ZERO;
		end else if (cmp) begin
			unique case (w)
				PBDP_W8: r = RATIO_CMP_X8;
				PBDP_W16: r = RATIO_CMP_X16;
				PBDP_W32: r = RATIO_CMP_X32;
				default: r = RATIO_ZERO;
			endcase
		end else if (aes) begin
			unique case (w)
				PBDP_W8: r = RATIO_AES_X8;
				PBDP_W16: r = RATIO_AES_X16;
				PBDP_W32: r = RATIO_AES_X32;
				default: r = RATIO_ZERO;
			endcase
		end else begin
			r = (w == PBDP_W8 || w == PBDP_W16 || w == PBDP_W32) ? RATIO_PLAIN : RATIO_ZERO;
		end
		return r;
	endfunction : pbdp_ratio
endpackage : pbdp_pkg

// *** rtl/pbdp_link_if.sv ***
// Link between the pacing host and the reconfiguration control end
`timescale 1ns/100ps
`default_nettype none
interface pbdp_link_if
	import pbdp_pkg::*;
	(
	input wire logic clk
);
	logic [DATA_W-1:0] data;
	logic data_valid;
	logic busy;
	logic [1:0] width_sel;
	logic aes_en;
	logic cmp_en;
	logic enh_en;

	modport host (
		input clk,
		output data,
		output data_valid,
		input busy,
		output width_sel,
		output aes_en,
		output cmp_en,
		output enh_en
	);
	modport device (
		input clk,
		input data,
		input data_valid,
		output busy,
		input width_sel,
		input aes_en,
		input cmp_en,
		input enh_en
	);
endinterface : pbdp_link_if
`default_nettype wire

// *** rtl/pbdp_fifo.sv ***
// Small synchronous FIFO with valid/ready on both sides
`timescale 1ns/100ps
`default_nettype none
module pbdp_fifo
	import pbdp_pkg::*;
	#(
	parameter int WIDTH = DATA_W,
	parameter int DEPTH = FIFO_DEPTH
) (
	// Clock and reset
	input wire logic clk,
	input wire logic reset_n,
	// Write side
	input wire logic [WIDTH-1:0] in_data,
	input wire logic in_valid,
	output logic in_ready,
	// Read side
	output logic [WIDTH-1:0] out_data,
	output logic out_valid,
	input wire logic out_ready
);
	localparam int AW = $clog2(DEPTH);
	logic [WIDTH-1:0] mem [DEPTH];
	logic [AW-1:0] wr_ptr;
	logic [AW-1:0] rd_ptr;
	logic [AW:0] count;
	wire do_wr = in_valid && in_ready;
	wire do_rd = out_valid && out_ready;

	// Honest flags from the occupancy count
	assign in_ready = (count != DEPTH[AW:0]);
	assign out_valid = (count != '0);
	assign out_data = mem[rd_ptr];

	// Storage
	always_ff @(posedge clk) begin
		if (do_wr) begin
			mem[wr_ptr] <= in_data;
		end
	end

	// Pointers wrap naturally since depth is a power of two
	always_ff @(posedge clk) begin
		if (!reset_n) begin
			wr_ptr <= '0;
			rd_ptr <= '0;
			count <= '0;
		end else begin
			wr_ptr <= do_wr ? wr_ptr + 1'b1 : wr_ptr;
			rd_ptr <= do_rd ? rd_ptr + 1'b1 : rd_ptr;
			count <= count + (AW+1)'(do_wr) - (AW+1)'(do_rd);
		end
	end
endmodule : pbdp_fifo
`default_nettype wire

// *** rtl/pbdp_host.sv ***
// Host end: paces configuration words onto the link at the data-hold ratio
`timescale 1ns/100ps
`default_nettype none
module pbdp_host
	import pbdp_pkg::*;
	(
	// Clock and reset
	input wire logic clk,
	input wire logic reset_n,
	// Link
	pbdp_link_if.host link,
	// Setup from user logic
	input wire logic [1:0] cfg_width,
	input wire logic cfg_aes,
	input wire logic cfg_cmp,
	input wire logic cfg_enh,
	// Word stream from user logic
	input wire logic [DATA_W-1:0] word_data,
	input wire logic word_valid,
	output logic word_ready,
	// Status
	output logic cfg_bad
);
	typedef enum logic [0:0] {HS_IDLE, HS_HOLD} pbdp_hstate_t;
	pbdp_hstate_t state;
	logic [RATIO_W-1:0] hold_cnt;
	logic [RATIO_W-1:0] ratio;
	logic [DATA_W-1:0] data_q;
	logic valid_q;
	logic word_ready_q;
	logic cfg_bad_q;
	logic [DATA_W-1:0] fifo_data;
	logic fifo_valid;
	logic fifo_ready;
	logic fifo_in_ready;
	localparam int OCC_W = $clog2(FIFO_DEPTH) + 1;
	logic [OCC_W-1:0] occ;
	// Ready is registered, so the host tracks occupancy itself to never overfill
	wire host_wr = word_valid && word_ready_q;
	wire [OCC_W-1:0] next_occ = occ + OCC_W'(host_wr) - OCC_W'(fifo_ready);

	// Exact ratio per bitstream type, never a shared minimum
	wire [RATIO_W-1:0] cfg_ratio = pbdp_ratio(pbdp_width_t'(cfg_width), cfg_aes, cfg_enh ? cfg_cmp : cfg_cmp, cfg_enh);
	wire cfg_illegal = (cfg_ratio == RATIO_ZERO);
	wire last_cycle = (hold_cnt == RATIO_ONE);
	wire take = (state == HS_IDLE || (state == HS_HOLD && last_cycle)) && fifo_valid && !cfg_illegal;
	assign fifo_ready = take;

	// Buffer absorbs bursts from user logic while pacing throttles the link
	pbdp_fifo #(
		.WIDTH(DATA_W),
		.DEPTH(FIFO_DEPTH)
	) u_fifo (
		.clk(clk),
		.reset_n(reset_n),
		.in_data(word_data),
		.in_valid(host_wr),
		.in_ready(fifo_in_ready),
		.out_data(fifo_data),
		.out_valid(fifo_valid),
		.out_ready(fifo_ready)
	);

	// Hold state machine: each word stays for ratio cycles
	always_ff @(posedge clk) begin
		if (!reset_n) begin
			state <= HS_IDLE;
			hold_cnt <= RATIO_ZERO;
			ratio <= RATIO_ONE;
			data_q <= '0;
			valid_q <= 1'b0;
		end else if (take) begin
			state <= HS_HOLD;
			hold_cnt <= cfg_ratio;
			ratio <= cfg_ratio;
			data_q <= fifo_data;
			valid_q <= 1'b1;
		end else if (state == HS_HOLD && last_cycle) begin
			state <= HS_IDLE;
			hold_cnt <= RATIO_ZERO;
			valid_q <= 1'b0;
		end else if (state == HS_HOLD) begin
			hold_cnt <= hold_cnt - RATIO_ONE; // Data lines untouched meanwhile
		end
	end

	// Registered status toward user logic
	always_ff @(posedge clk) begin
		if (!reset_n) begin
			word_ready_q <= 1'b0;
			cfg_bad_q <= 1'b0;
			occ <= '0;
		end else begin
			occ <= next_occ;
			word_ready_q <= (next_occ != FIFO_DEPTH[OCC_W-1:0]);
			cfg_bad_q <= cfg_illegal;
		end
	end

	// Mode and width travel with the data so the far end can check pacing
	assign link.data = data_q;
	assign link.data_valid = valid_q;
	assign link.width_sel = cfg_width;
	assign link.aes_en = cfg_aes;
	assign link.cmp_en = cfg_cmp;
	assign link.enh_en = cfg_enh;
	assign word_ready = word_ready_q;
	assign cfg_bad = cfg_bad_q;
endmodule : pbdp_host
`default_nettype wire

// *** rtl/pbdp_device.sv ***
// Device end: checks pacing, accepts words, holds keys for decryption
`timescale 1ns/100ps
`default_nettype none
module pbdp_device
	import pbdp_pkg::*;
	(
	// Clock and reset
	input wire logic clk,
	input wire logic reset_n,
	// Link
	pbdp_link_if.device link,
	// Key setup from user logic
	input wire logic [KEY_W-1:0] key_volatile,
	input wire logic [KEY_W-1:0] key_otp,
	input wire logic base_encrypted,
	input wire logic base_keystore,
	input wire logic part_keystore,
	// Accepted words
	output logic [DATA_W-1:0] word_out,
	output logic word_strobe,
	output logic [KEY_W-1:0] active_key,
	// Errors
	output logic mode_error,
	output logic hold_error
);
	logic [RATIO_W-1:0] pos;
	logic [DATA_W-1:0] hold_d;
	logic [DATA_W-1:0] word_q;
	logic strobe_q;
	logic [KEY_W-1:0] key_q;
	logic mode_err_q;
	logic hold_err_q;

	// Same ratio table as the host
	wire [RATIO_W-1:0] need = pbdp_ratio(pbdp_width_t'(link.width_sel), link.aes_en, link.cmp_en, link.enh_en);
	wire bad_mode = (need == RATIO_ZERO);
	// Position within the current hold; last beat completes the word
	wire last_beat = (pos + RATIO_ONE == need);
	wire take_word = link.data_valid && !bad_mode && last_beat;
	// A hold cut short or a word changed mid-hold
	wire short_hold = (pos != RATIO_ZERO) && (!link.data_valid || link.data != hold_d);
	// Partial image key picked independently of base image
	wire [KEY_W-1:0] part_key = (pbdp_keystore_t'(part_keystore) == PBDP_KEY_OTP) ? key_otp : key_volatile;
	wire unused_base = base_encrypted ^ base_keystore;

	// Count cycles each word stands; word taken once its hold completes
	always_ff @(posedge clk) begin
		if (!reset_n) begin
			pos <= RATIO_ZERO;
			hold_d <= '0;
			word_q <= '0;
			strobe_q <= 1'b0;
		end else begin
			pos <= (!link.data_valid || bad_mode || last_beat) ? RATIO_ZERO : pos + RATIO_ONE;
			hold_d <= (link.data_valid && pos == RATIO_ZERO) ? link.data : hold_d;
			strobe_q <= take_word;
			word_q <= take_word ? link.data : word_q;
		end
	end

	// Sticky error flags; short holds are flagged
	always_ff @(posedge clk) begin
		if (!reset_n) begin
			mode_err_q <= 1'b0;
			hold_err_q <= 1'b0;
			key_q <= '0;
		end else begin
			mode_err_q <= mode_err_q | bad_mode; // Flag even with nothing sent
			hold_err_q <= hold_err_q | short_hold;
			key_q <= link.aes_en ? part_key : key_q; // 256-bit key
		end
	end

	// Device never stalls; busy reports a refused configuration
	assign link.busy = mode_err_q;
	assign word_out = word_q;
	assign word_strobe = strobe_q;
	assign active_key = key_q;
	assign mode_error = mode_err_q;
	assign hold_error = hold_err_q;
endmodule : pbdp_device
`default_nettype wire

// *** dv/pbdp_link_assertions.sv ***
// Pacing checks on the link between host and device
`timescale 1ns/100ps
`default_nettype none
module pbdp_link_assertions
	import pbdp_pkg::*;
	(
	// Clock and reset
	input wire logic clk,
	input wire logic reset_n,
	// Link
	input wire logic [DATA_W-1:0] data,
	input wire logic data_valid,
	input wire logic busy,
	input wire logic [1:0] width_sel,
	input wire logic aes_en,
	input wire logic cmp_en,
	input wire logic enh_en
);
	logic prev_v;
	logic [DATA_W-1:0] prev_d;
	logic [3:0] cnt;
	// A hold starts on a new word and ends when it leaves; equal neighbours would merge
	wire start = data_valid && (!prev_v || data != prev_d);
	wire hold_end = prev_v && (!data_valid || data != prev_d);
	wire [3:0] next_cnt = start ? 4'h1 : (data_valid ? cnt + 4'h1 : 4'h0);
	// Length of the current hold
	always_ff @(posedge clk) begin
		prev_v <= reset_n && data_valid;
		prev_d <= data;
		cnt <= reset_n ? next_cnt : 4'h0;
	end
	default clocking cb @(posedge clk);
	endclocking
	default disable iff (!reset_n);
	sequence held_seven;
		(data_valid && $stable(data))[*7];
	endsequence
	a_plain_hold_one: assert property (hold_end && !aes_en && !cmp_en |-> cnt == 4'h1)
		else $error("plain word held wrong count");
	a_cmp_hold_width: assert property (hold_end && cmp_en && !aes_en && !enh_en |->
		cnt == (width_sel == 2'h0 ? 4'h2 : width_sel == 2'h1 ? 4'h4 : 4'h8))
		else $error("compressed word held wrong count");
	a_aes_hold_width: assert property (hold_end && aes_en && !cmp_en && !enh_en |->
		cnt == (width_sel == 2'h0 ? 4'h1 : width_sel == 2'h1 ? 4'h2 : 4'h4))
		else $error("encrypted word held wrong count");
	a_enh_cmp_four: assert property (hold_end && cmp_en && enh_en && !aes_en |-> cnt == 4'h4)
		else $error("enhanced compressed word held wrong count");
	a_cmp32_steady: assert property (start && cmp_en && !aes_en && !enh_en && width_sel == 2'h2 |=>
		held_seven ##1 hold_end)
		else $error("x32 compressed word not steady for eight cycles");
	a_aes_cmp_silent: assert property (aes_en && cmp_en |-> !data_valid)
		else $error("word sent with encryption and compression");
	a_enh_aes_silent: assert property (aes_en && enh_en |-> !data_valid)
		else $error("word sent with encryption and enhanced mode");
	a_illegal_flagged: assert property (aes_en && (cmp_en || enh_en) |-> ##[0:4] busy)
		else $error("illegal mode not flagged");
	a_error_sticky: assert property (busy |=> busy)
		else $error("error flag dropped before reset");
endmodule : pbdp_link_assertions
`default_nettype wire

// *** dv/pr_bitstream_data_pacing_tb.sv ***
// Self-checking bench for the pacing host and device pair
`timescale 1ns/100ps
`default_nettype none
module pr_bitstream_data_pacing_tb
	import pbdp_pkg::*;
	;
	logic clk = 1'b0;
	logic reset_n = 1'b0;
	logic [1:0] cfg_width = 2'h0;
	logic cfg_aes = 1'b0, cfg_cmp = 1'b0, cfg_enh = 1'b0;
	logic [DATA_W-1:0] word_data = '0;
	logic word_valid = 1'b0;
	logic word_ready, cfg_bad, word_strobe, mode_error, hold_error;
	logic [KEY_W-1:0] key_volatile = '0, key_otp = '0, active_key;
	logic base_encrypted = 1'b1, base_keystore = 1'b1, part_keystore = 1'b0;
	logic [DATA_W-1:0] word_out;
	logic [DATA_W-1:0] exp_q[$];
	int fails = 0, n_checks = 0, seed = 95, stalls = 0;
	// 40 MHz clock
	initial forever #12.5 clk = ~clk;
	pbdp_link_if pbdp_link_if_i (.clk(clk));
	pbdp_host pbdp_host_i (.clk(clk), .reset_n(reset_n), .link(pbdp_link_if_i), .cfg_width(cfg_width),
		.cfg_aes(cfg_aes), .cfg_cmp(cfg_cmp), .cfg_enh(cfg_enh), .word_data(word_data),
		.word_valid(word_valid), .word_ready(word_ready), .cfg_bad(cfg_bad));
	pbdp_device pbdp_device_i (.clk(clk), .reset_n(reset_n), .link(pbdp_link_if_i),
		.key_volatile(key_volatile), .key_otp(key_otp), .base_encrypted(base_encrypted),
		.base_keystore(base_keystore), .part_keystore(part_keystore), .word_out(word_out),
		.word_strobe(word_strobe), .active_key(active_key), .mode_error(mode_error), .hold_error(hold_error));
	pbdp_link_assertions pbdp_link_assertions_i (.clk(clk), .reset_n(reset_n), .data(pbdp_link_if_i.data),
		.data_valid(pbdp_link_if_i.data_valid), .busy(pbdp_link_if_i.busy), .width_sel(pbdp_link_if_i.width_sel),
		.aes_en(pbdp_link_if_i.aes_en), .cmp_en(pbdp_link_if_i.cmp_en), .enh_en(pbdp_link_if_i.enh_en));
	task automatic give_verdict();
		$display("Checks %0d, mismatches %0d", n_checks, fails);
		if (fails == 0 && n_checks > 0) begin
			$display("== PASSED ==");
		end else begin
			$display("== FAILED ==");
		end
		$finish;
	endtask : give_verdict
	task automatic check(input logic [KEY_W-1:0] got, input logic [KEY_W-1:0] exp);
		n_checks++;
		if (got !== exp) begin
			fails++;
			$display("Error at %0t: got %h expected %h", $time, got, exp);
		end
	endtask : check
	task automatic do_reset();
		reset_n = 1'b0;
		repeat (5) @(posedge clk);
		#1 reset_n = 1'b1;
	endtask : do_reset
	task automatic mode(input logic [1:0] w, input logic a, input logic c, input logic e);
		cfg_width = w;
		cfg_aes = a;
		cfg_cmp = c;
		cfg_enh = e;
		repeat (3) @(posedge clk);
		#1;
	endtask : mode
	// Words go in back to back; a refusal waits, bounded
	task automatic send(input int n);
		int t;
		for (int i = 0; i < n; i++) begin
			word_data = $random(seed);
			word_valid = 1'b1;
			t = 0;
			while (word_ready !== 1'b1 && t < 400) begin
				@(posedge clk);
				#1 t++;
				stalls++;
			end
			if (t >= 400) begin
				fails++;
				give_verdict();
			end
			exp_q.push_back(word_data);
			@(posedge clk);
			#1;
		end
		word_valid = 1'b0;
	endtask : send
	task automatic drain();
		int t = 0;
		while (exp_q.size() != 0 && t < 2000) begin
			@(posedge clk);
			t++;
		end
		if (exp_q.size() != 0) begin
			fails++;
			give_verdict();
		end
		repeat (4) @(posedge clk);
		#1;
	endtask : drain
	// Each accepted word against the oldest note
	always @(posedge clk) begin
		if (reset_n && word_strobe === 1'b1) begin
			if (exp_q.size() == 0) begin
				fails++;
				$display("Error at %0t: got %h expected %h", $time, word_out, 0);
			end else begin
				check(word_out, exp_q.pop_front());
			end
		end
	end
	// Main sequence: legal modes, a full buffer, keys, then refused modes
	initial begin
		int g;
		key_volatile = {8{$random(seed)}};
		key_otp = {8{$random(seed)}};
		do_reset();
		for (int m = 0; m < 15; m++) begin
			g = m / 3;
			mode(2'(m % 3), g == 2, g == 1 || g == 4, g >= 3);
			send(3);
			drain();
			$display("Mode %0d done", m);
		end
		mode(2'h2, 1'b0, 1'b1, 1'b0);
		stalls = 0;
		send(12);
		check(stalls != 0, 1'b1);
		drain();
		$display("Fill done");
		mode(2'h2, 1'b1, 1'b0, 1'b0);
		for (int k = 0; k < 2; k++) begin
			part_keystore = k[0];
			send(1);
			drain();
			check(active_key, k ? key_otp : key_volatile);
		end
		$display("Keys done");
		for (int k = 0; k < 3; k++) begin
			mode(k == 2 ? 2'h3 : 2'(k), k < 2, k == 0, k == 1);
			check(cfg_bad, 1'b1);
			check(mode_error, 1'b1);
			mode(2'h0, 1'b0, 1'b0, 1'b0);
			do_reset();
		end
		$display("Refusals done");
		check(hold_error, 1'b0);
		give_verdict();
	end
endmodule : pr_bitstream_data_pacing_tb
`default_nettype wire
